//--- swgd_pkg.sv
// Constants shared by the sleep, wake and gate drive control block.
package swgd_pkg;
    // ------------------------------------------------------------------
    // Register map (word index, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL    = 6'h00;
    localparam logic [5:0] IDX_BAL     = 6'h01;
    localparam logic [5:0] IDX_IRQ_STS = 6'h02;
    localparam logic [5:0] IDX_IRQ_MSK = 6'h03;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_SLP_BIT  = 7;
    localparam int CTRL_EXT_BIT  = 6;
    localparam int CTRL_MON_BIT  = 5;
    localparam int CTRL_RSV_LSB  = 3;
    localparam int CTRL_SEL_LSB  = 0;

    // ------------------------------------------------------------------
    // Interrupt status fields
    // ------------------------------------------------------------------
    localparam int IRQ_WAKE_SET_BIT = 0;
    localparam int IRQ_WAKE_CLR_BIT = 1;
    localparam int IRQ_SLEEP_BIT    = 2;
    localparam int IRQ_W            = 3;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]       CTRL_RST = 8'h00;
    localparam logic [7:0]       BAL_RST  = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int FLAG_SET_NS    = 10000;
    localparam int WAKE_PULSE_NS  = 1000000;
    localparam int FLAG_SET_CYC   = (FLAG_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUAL_CNT_W     = 16;
endpackage

//--- swgd_sync.sv
// Two flip-flop synchroniser, one stage pair per input bit.
`timescale 1ns/1ps
module swgd_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [W-1:0] meta_q;

    // The first stage feeds only the second, so metastability never reaches logic.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule

//--- swgd_wake_qual.sv
// Pulse width qualifier for the high-voltage wake comparator level.
`timescale 1ns/1ps
module swgd_wake_qual (
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    input  wire logic                           level,
    input  wire logic [swgd_pkg::QUAL_CNT_W-1:0] need_cyc,
    output logic                                qualified
);
    // ------------------------------------------------------------------
    // Width counter
    // ------------------------------------------------------------------
    logic [swgd_pkg::QUAL_CNT_W-1:0] cnt_q;

    // Restarts on every drop below threshold, saturates so a long level holds.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!level) begin
            cnt_q <= '0;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Qualified only once the level has stood for the full width.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            qualified <= 1'b0;
        end else begin
            qualified <= level && (cnt_q >= need_cyc - 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_qual_drop_clears: assert property (!level |=> !qualified)
        else $error("qualifier held while level low");
    a_qual_full_width: assert property (
        $rose(qualified) |-> $past(cnt_q) >= need_cyc - 1'b1)
        else $error("qualifier rose before full width");
endmodule

//--- swgd_top.sv
// Sleep, wake and gate driver enable control with a Wishbone register slave.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module swgd_top #(
    parameter int WAKE_PULSE_CYC = swgd_pkg::WAKE_PULSE_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        ARST_N,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        DISCH_CTRL_IN_A,
    input  wire logic        DISCH_CTRL_IN_B,
    input  wire logic        CHARGE_CTRL_IN,
    input  wire logic        HV_WAKE_ABOVE_TH,
    input  wire logic        HV_WAKE_ABOVE_CLR,
    output logic             DISCH_GATE_OUT_A,
    output logic             DISCH_GATE_OUT_B,
    output logic             CHARGE_GATE_OUT,
    output logic             REGULATOR_EN,
    output logic             MONITOR_EN,
    output logic      [2:0]  MONITOR_SEL,
    output logic      [7:0]  BALANCE_EN,
    output logic             IRQ
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [4:0] pins_s;
    logic       dn_a_s;
    logic       dn_b_s;
    logic       chg_s;
    logic       wk_th_s;
    logic       wk_clr_s;

    // Pins are asynchronous to CLK_SYS; a floating pin is pulled low outside.
    swgd_sync #(.W(5)) u_sync (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .async_in ({HV_WAKE_ABOVE_CLR, HV_WAKE_ABOVE_TH, CHARGE_CTRL_IN,
                    DISCH_CTRL_IN_B, DISCH_CTRL_IN_A}),
        .sync_out (pins_s)
    );
    assign dn_a_s   = pins_s[0];
    assign dn_b_s   = pins_s[1];
    assign chg_s    = pins_s[2];
    assign wk_th_s  = pins_s[3];
    assign wk_clr_s = pins_s[4];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic             slp_q;
    logic             ext_hw_q;
    logic             ext_sw_q;
    logic             mon_en_q;
    logic [1:0]       rsv_q;
    logic [2:0]       sel_q;
    logic [7:0]       bal_q;
    logic [swgd_pkg::IRQ_W-1:0] sts_q;
    logic [swgd_pkg::IRQ_W-1:0] msk_q;
    logic             ext_any;
    logic             req;
    logic             wr_en;
    logic             wr_ctrl;
    logic [5:0]       idx;
    logic [7:0]       wd;
    logic             sleep_cmd;
    logic             wake_qual;
    logic [swgd_pkg::QUAL_CNT_W-1:0] need_cyc;
    logic [swgd_pkg::IRQ_W-1:0] sts_set;
    logic [31:0]      rd_d;

    // A request is taken in the cycle before ACK_O rises; writes land at that edge.
    assign req       = CYC_I && STB_I && !ACK_O;
    assign wr_en     = req && WE_I && SEL_I[0];
    assign idx       = ADR_I[7:2];
    assign wd        = DAT_I[7:0];
    assign wr_ctrl   = wr_en && (idx == swgd_pkg::IDX_CTRL);
    assign ext_any   = ext_hw_q || ext_sw_q;
    // Both bits written high is illegal; it is treated as no sleep request.
    assign sleep_cmd = wr_ctrl && wd[swgd_pkg::CTRL_SLP_BIT] && !wd[swgd_pkg::CTRL_EXT_BIT]
                       && !ext_any;

    // ------------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------------
    // Awake the flag needs 10 us; asleep it needs the full wake pulse width.
    assign need_cyc = slp_q ? swgd_pkg::QUAL_CNT_W'(WAKE_PULSE_CYC)
                            : swgd_pkg::QUAL_CNT_W'(swgd_pkg::FLAG_SET_CYC);

    swgd_wake_qual u_qual (
        .clk       (CLK_SYS),
        .arst_n    (ARST_N),
        .level     (wk_th_s),
        .need_cyc  (need_cyc),
        .qualified (wake_qual)
    );

    // Pin-driven flag; removal of the source clears it at once, over a set.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ext_hw_q <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_EXT_BIT];
        end else if (!wk_clr_s) begin
            ext_hw_q <= 1'b0;
        end else if (wake_qual) begin
            ext_hw_q <= 1'b1;
        end
    end

    // Software-written wake flag; it also blocks sleep until written back to 0.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ext_sw_q <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_EXT_BIT];
        end else if (wr_ctrl) begin
            ext_sw_q <= wd[swgd_pkg::CTRL_EXT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Sleep state
    // ------------------------------------------------------------------
    // A set wake flag holds the sleep bit at zero and drops sleep commands.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            slp_q <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_SLP_BIT];
        end else if (ext_any) begin
            slp_q <= 1'b0;
        end else if (wr_ctrl) begin
            slp_q <= sleep_cmd;
        end
    end

    // Monitor enable, reserved bits and channel select are plain storage.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            mon_en_q <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_MON_BIT];
            rsv_q    <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_RSV_LSB +: 2];
            sel_q    <= swgd_pkg::CTRL_RST[swgd_pkg::CTRL_SEL_LSB +: 3];
        end else if (wr_ctrl) begin
            mon_en_q <= wd[swgd_pkg::CTRL_MON_BIT];
            rsv_q    <= wd[swgd_pkg::CTRL_RSV_LSB +: 2];
            sel_q    <= wd[swgd_pkg::CTRL_SEL_LSB +: 3];
        end
    end

    // Balance switches; a sleep command turns every one off.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            bal_q <= swgd_pkg::BAL_RST;
        end else if (sleep_cmd) begin
            bal_q <= '0;
        end else if (wr_en && idx == swgd_pkg::IDX_BAL) begin
            bal_q <= wd;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Registered from synchronised pins so the gates never see a glitch.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            DISCH_GATE_OUT_A <= 1'b0;
            DISCH_GATE_OUT_B <= 1'b0;
            CHARGE_GATE_OUT  <= 1'b0;
        end else begin
            DISCH_GATE_OUT_A <= !slp_q && dn_a_s;
            DISCH_GATE_OUT_B <= !slp_q && dn_b_s;
            CHARGE_GATE_OUT  <= !slp_q && chg_s;
        end
    end

    // Regulator and monitor are shut down in sleep; registers other than the balance register keep their values.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            REGULATOR_EN <= 1'b0;
            MONITOR_EN   <= 1'b0;
            MONITOR_SEL  <= 3'h0;
            BALANCE_EN   <= 8'h00;
        end else begin
            REGULATOR_EN <= !slp_q;
            MONITOR_EN   <= !slp_q && mon_en_q;
            MONITOR_SEL  <= sel_q;
            BALANCE_EN   <= slp_q ? 8'h00 : bal_q;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        sts_set = '0;
        sts_set[swgd_pkg::IRQ_WAKE_SET_BIT] = wake_qual && wk_clr_s && !ext_hw_q;
        sts_set[swgd_pkg::IRQ_WAKE_CLR_BIT] = !wk_clr_s && ext_hw_q;
        sts_set[swgd_pkg::IRQ_SLEEP_BIT]    = sleep_cmd && !slp_q;
    end

    // Write one to clear; an event in the same cycle wins over the clear.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sts_q <= swgd_pkg::IRQ_RST;
        end else if (wr_en && idx == swgd_pkg::IDX_IRQ_STS) begin
            sts_q <= (sts_q & ~wd[swgd_pkg::IRQ_W-1:0]) | sts_set;
        end else begin
            sts_q <= sts_q | sts_set;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            msk_q <= swgd_pkg::IRQ_RST;
        end else if (wr_en && idx == swgd_pkg::IDX_IRQ_MSK) begin
            msk_q <= wd[swgd_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(sts_q & msk_q);
        end
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Bit 6 reads the pin-driven flag only, never the software copy.
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (idx)
            swgd_pkg::IDX_CTRL:    rd_d[7:0] = {slp_q, ext_hw_q, mon_en_q, rsv_q, sel_q};
            swgd_pkg::IDX_BAL:     rd_d[7:0] = bal_q;
            swgd_pkg::IDX_IRQ_STS: rd_d[swgd_pkg::IRQ_W-1:0] = sts_q;
            swgd_pkg::IDX_IRQ_MSK: rd_d[swgd_pkg::IRQ_W-1:0] = msk_q;
            default:               rd_d = 32'h0000_0000;
        endcase
    end

    // One wait-free answer; unmapped addresses ack with zero and ignore writes.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= req;
            DAT_O <= req ? rd_d : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    sequence s_sleep_write;
        sleep_cmd ##1 slp_q;
    endsequence

    a_gate_b_low: assert property (!dn_b_s |=> !DISCH_GATE_OUT_B)
        else $error("second discharge gate on with control low");
    a_charge_gate_on: assert property (CHARGE_GATE_OUT |-> $past(chg_s) && !$past(slp_q))
        else $error("charge gate on without cause");
    a_charge_low_off: assert property (!chg_s |=> !CHARGE_GATE_OUT)
        else $error("charge gate on with control low");
    a_sleep_charge_off: assert property (slp_q |=> !CHARGE_GATE_OUT)
        else $error("charge gate on in sleep");
    a_sleep_entry: assert property (sleep_cmd |=> slp_q)
        else $error("sleep command not taken");
    a_sleep_outputs: assert property (s_sleep_write |=> !REGULATOR_EN && !MONITOR_EN
                                      && !DISCH_GATE_OUT_A && BALANCE_EN == 8'h00)
        else $error("outputs not shut in sleep");
    a_flag_blocks_sleep: assert property (ext_any |=> !slp_q)
        else $error("sleep bit set while wake flag set");
    a_wake_restores: assert property ($fell(slp_q) |=> REGULATOR_EN)
        else $error("regulator not restored on wake");
    a_flag_clears: assert property (!wk_clr_s |=> !ext_hw_q)
        else $error("wake flag held after source removed");
    a_balance_off: assert property (sleep_cmd |=> bal_q == 8'h00)
        else $error("balance switch left on by sleep");
    a_bus_ack: assert property (req |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single cycle");
endmodule

//--- swgd_host_model.sv
// Host side model that drives the gate control and wake comparator pins.
`timescale 1ns/1ps
module swgd_host_model (
    input  wire logic       clk,
    input  wire logic [2:0] gate_drv,
    input  wire logic [2:0] gate_lvl,
    input  wire logic       wake_th,
    input  wire logic       wake_clr,
    output logic      [2:0] gate_pin,
    output logic            th_pin,
    output logic            clr_pin
);
    // ----------
    // Pin drivers
    // ----------
    // Pins start low, as the pull-downs hold them before the host acts.
    initial begin
        gate_pin = 3'h0;
        th_pin   = 1'b0;
        clr_pin  = 1'b0;
    end

    // A released pin falls to its pull-down level, never its last value.
    // The threshold output is gated by the clear level, because the wake pin
    // cannot sit above the wake threshold while it is below 1.5 V.
    always @(posedge clk) begin
        gate_pin <= gate_drv & gate_lvl;
        th_pin   <= wake_th & wake_clr;
        clr_pin  <= wake_clr;
    end
endmodule

//--- test_sleep_wake_gate_drive_control.sv
// Self-checking bench for the sleep, wake and gate drive control block.
`timescale 1ns/1ps
module test_sleep_wake_gate_drive_control;
    // ----------
    // Design, host model and bus signals
    // ----------
    localparam int         WAKE_CYC = 40;
    localparam logic [7:0] A_CTRL   = {swgd_pkg::IDX_CTRL, 2'b00};
    localparam logic [7:0] A_BAL    = {swgd_pkg::IDX_BAL, 2'b00};
    localparam logic [7:0] A_STS    = {swgd_pkg::IDX_IRQ_STS, 2'b00};
    localparam logic [7:0] A_MSK    = {swgd_pkg::IDX_IRQ_MSK, 2'b00};
    logic        clk      = 1'b0;
    logic        arst_n   = 1'b0;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [3:0]  sel      = 4'h0;
    logic [31:0] dat_w    = 32'h0000_0000;
    logic [2:0]  gate_drv = 3'h0;
    logic [2:0]  gate_lvl = 3'h0;
    logic        wake_th  = 1'b0;
    logic        wake_clr = 1'b1;
    logic [31:0] q;
    int          failures = 0;
    int          compares = 0;
    int          cycles   = 0;
    wire  [31:0] dat_r;
    wire         ack;
    wire  [2:0]  gate_pin;
    wire         th_pin;
    wire         clr_pin;
    wire  [2:0]  gate_out;
    wire         reg_en;
    wire         mon_en;
    wire  [2:0]  mon_sel;
    wire  [7:0]  bal_en;
    wire         irq;

    swgd_host_model host (
        .clk(clk), .gate_drv(gate_drv), .gate_lvl(gate_lvl), .wake_th(wake_th),
        .wake_clr(wake_clr), .gate_pin(gate_pin), .th_pin(th_pin), .clr_pin(clr_pin)
    );

    // A short wake width keeps the sleep scenarios brief.
    swgd_top #(.WAKE_PULSE_CYC(WAKE_CYC)) dut (
        .CLK_SYS(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .DISCH_CTRL_IN_A(gate_pin[0]), .DISCH_CTRL_IN_B(gate_pin[1]),
        .CHARGE_CTRL_IN(gate_pin[2]), .HV_WAKE_ABOVE_TH(th_pin),
        .HV_WAKE_ABOVE_CLR(clr_pin), .DISCH_GATE_OUT_A(gate_out[0]),
        .DISCH_GATE_OUT_B(gate_out[1]), .CHARGE_GATE_OUT(gate_out[2]),
        .REGULATOR_EN(reg_en), .MONITOR_EN(mon_en), .MONITOR_SEL(mon_sel),
        .BALANCE_EN(bal_en), .IRQ(irq)
    );

    // Clock at 20 MHz.
    initial begin
        forever #25 clk = ~clk;
    end

    // ----------
    // Checking and bus tasks
    // ----------
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the whole run needs under 2000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic cycle: request held until ack is seen at an edge, then released.
    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                      input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        dat_w <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(a, 1'b1, 4'hF, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        wb(a, 1'b0, 4'hF, 8'h00, q);
        chk(nm, q, {24'h00_0000, e});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ----------
    // Scenarios
    // ----------
    initial begin
        int n;
        logic [2:0] g;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd("ctrl", A_CTRL, 8'h00);
        rd("bal", A_BAL, 8'h00);
        rd("sts", A_STS, 8'h00);
        rd("msk", A_MSK, 8'h00);
        chk("reg_en", 32'(reg_en), 32'h0000_0001);
        // Every gate control pin is driven low, driven high and left floating at some point.
        for (int i = 0; i < 16; i++) begin
            g = i[3] ? 3'h5 : 3'h2;
            gate_drv <= g;
            gate_lvl <= i[2:0];
            wait_cyc(6);
            chk("gates", 32'(gate_out), 32'(g & i[2:0]));
        end
        gate_drv <= 3'h7;
        gate_lvl <= 3'h7;
        // One channel is selected and never converted, so settle time and scan rate hold.
        wr(A_CTRL, 8'h3D);
        rd("ctrl", A_CTRL, 8'h3D);
        chk("mon", 32'({mon_en, mon_sel}), 32'h0000_000D);
        wr(A_BAL, 8'hA5);
        wb(A_BAL, 1'b1, 4'hE, 8'hFF, q);
        rd("bal", A_BAL, 8'hA5);
        chk("bal_en", 32'(bal_en), 32'h0000_00A5);
        rd("unmapped", 8'h10, 8'h00);
        wr(A_MSK, 8'h04);
        // Sleep with every gate requested on; the wake flag bit stays 0.
        wr(A_CTRL, 8'hBD);
        wait_cyc(3);
        chk("outs", 32'({gate_out, reg_en, mon_en, bal_en}), 32'h0000_0000);
        chk("irq", 32'(irq), 32'h0000_0001);
        rd("ctrl", A_CTRL, 8'hBD);
        rd("bal", A_BAL, 8'h00);
        rd("sts", A_STS, 8'h04);
        wr(A_STS, 8'h04);
        wait_cyc(2);
        chk("irq", 32'(irq), 32'h0000_0000);
        // Two short pulses whose sum exceeds the width must not wake.
        repeat (2) begin
            wake_th <= 1'b1;
            wait_cyc(WAKE_CYC - 10);
            wake_th <= 1'b0;
            wait_cyc(4);
        end
        wait_cyc(WAKE_CYC);
        chk("asleep", 32'(reg_en), 32'h0000_0000);
        wake_th <= 1'b1;
        n = 0;
        while (reg_en !== 1'b1 && n < WAKE_CYC + 20) begin
            @(posedge clk);
            n++;
        end
        chk("wake_width", 32'(n >= WAKE_CYC && reg_en === 1'b1), 32'h0000_0001);
        wait_cyc(2);
        rd("ctrl", A_CTRL, 8'h7D);
        chk("outs", 32'({gate_out, mon_en}), 32'h0000_000F);
        wr(A_CTRL, 8'hBD);
        rd("ctrl", A_CTRL, 8'h7D);
        chk("reg_en", 32'(reg_en), 32'h0000_0001);
        rd("sts", A_STS, 8'h01);
        chk("irq", 32'(irq), 32'h0000_0000);
        wr(A_MSK, 8'h01);
        wait_cyc(2);
        chk("irq", 32'(irq), 32'h0000_0001);
        wr(A_STS, 8'h01);
        wait_cyc(2);
        chk("irq", 32'(irq), 32'h0000_0000);
        // Source removed: the flag drops at once and the set time restarts.
        wake_clr <= 1'b0;
        wait_cyc(5);
        rd("ctrl", A_CTRL, 8'h3D);
        rd("sts", A_STS, 8'h02);
        wake_clr <= 1'b1;
        wait_cyc(150);
        rd("ctrl", A_CTRL, 8'h3D);
        wait_cyc(100);
        rd("ctrl", A_CTRL, 8'h7D);
        wr(A_CTRL, 8'h00);
        rd("ctrl", A_CTRL, 8'h40);
        // The software wake flag is not read back in bit 6, and it drops one sleep command.
        wake_clr <= 1'b0;
        wait_cyc(5);
        wr(A_CTRL, 8'h40);
        wr(A_CTRL, 8'h80);
        rd("ctrl", A_CTRL, 8'h00);
        chk("reg_en", 32'(reg_en), 32'h0000_0001);
        wr(A_CTRL, 8'h80);
        wait_cyc(3);
        chk("reg_en", 32'(reg_en), 32'h0000_0000);
        rd("ctrl", A_CTRL, 8'h80);
        test_done();
    end
endmodule
